// ==== hw/adctsc_map.vh ====
// Register map, field positions and reset values of the trigger and scan control.
// Assumes an 8-bit I/O port on the card's host bus, offsets relative to the card base.
`ifndef ADCTSC_MAP_VH
`define ADCTSC_MAP_VH

// ==========================================================================
// Offsets
`define ADCTSC_OFS_CONV_DATA 8'h00
`define ADCTSC_OFS_CHAN_MUX 8'h06
`define ADCTSC_OFS_GAIN 8'h08
`define ADCTSC_OFS_TRIG_MODE 8'h0a
`define ADCTSC_OFS_SOFT_TRIG 8'h0e
`define ADCTSC_OFS_MODE_READBACK 8'h12
`define ADCTSC_OFS_TMR_CNT0 8'h40
`define ADCTSC_OFS_TMR_CNT1 8'h42
`define ADCTSC_OFS_TMR_CNT2 8'h44
`define ADCTSC_OFS_TMR_CTRL 8'h46

// ==========================================================================
// Timer window decode
`define ADCTSC_TMR_BASE_MASK 8'hf8
`define ADCTSC_TMR_BASE 8'h40
`define ADCTSC_TMR_SEL_HI 2
`define ADCTSC_TMR_SEL_LO 1
`define ADCTSC_TMR_SEL_CTRL 2'h3

// ==========================================================================
// Trigger mode register fields
`define ADCTSC_BIT_AUTO_SCAN 0
`define ADCTSC_BIT_PACER_SOFT 1
`define ADCTSC_BIT_TRIG_ORIGIN 2
`define ADCTSC_BIT_PRETRIG 3
`define ADCTSC_MODE_W 4
`define ADCTSC_GAIN_W 3

// ==========================================================================
// Timer control word fields
`define ADCTSC_CW_SEL_HI 7
`define ADCTSC_CW_SEL_LO 6
`define ADCTSC_CW_RUN 0

// ==========================================================================
// Gain codes and factors
`define ADCTSC_GCODE_X1 3'h0
`define ADCTSC_GCODE_X2 3'h1
`define ADCTSC_GCODE_X4 3'h2
`define ADCTSC_GCODE_X8 3'h3
`define ADCTSC_GCODE_X16 3'h4
`define ADCTSC_GAIN_X1 5'h01
`define ADCTSC_GAIN_X2 5'h02
`define ADCTSC_GAIN_X4 5'h04
`define ADCTSC_GAIN_X8 5'h08
`define ADCTSC_GAIN_X16 5'h10

// ==========================================================================
// Reset values
`define ADCTSC_RST_MUX 8'h00
`define ADCTSC_RST_GAIN 3'h0
`define ADCTSC_RST_MODE 4'h0
`define ADCTSC_RST_CNT 8'h00
`define ADCTSC_RST_CW 8'h00

`endif

// ==== hw/adctsc_interval_timer.v ====
// Three 8-bit interval counters with a write-only control word.
// Assumes single-cycle write strobes on ref_clk; read data is combinational.
`timescale 1ns/100ps
`include "adctsc_map.vh"

module adctsc_interval_timer #(
  parameter NUM_CNT = 3
) (
  input wire ref_clk, // System clock
  input wire rst_n, // Asynchronous reset, active low
  input wire wrStb, // Write strobe into the timer window
  input wire [1:0] sel, // Counter index, 3 is the control word
  input wire [7:0] wrData, // Write data
  output reg [7:0] rdData, // Current count of the selected counter
  output wire pacerTick // One-cycle pulse when the cascade wraps
);

  // ==========================================================================
  // Control word is not stored; each counter keeps only its own run enable
  wire [NUM_CNT*8-1:0] cntFlat;
  wire [NUM_CNT-1:0] wrap;

  // ==========================================================================
  // Counters; 1 and 2 cascade to pace conversions
  genvar i;
  generate
    for (i = 0; i < NUM_CNT; i = i + 1) begin : gCnt
      localparam [1:0] IDX = i;
      reg [7:0] cnt;
      reg [7:0] reload;
      reg run;
      reg wrapped;
      wire tick;
      // Counter 2 steps only on counter 1 wraps; the others on every clock
      if (i == 2) begin : gCasc
        assign tick = wrap[1];
      end else begin : gFree
        assign tick = 1'b1;
      end
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt <= `ADCTSC_RST_CNT;
          reload <= `ADCTSC_RST_CNT;
          run <= 1'b0;
          wrapped <= 1'b0;
        end else begin
          wrapped <= 1'b0;
          if (wrStb && sel == IDX) begin
            cnt <= wrData;
            reload <= wrData;
          end else if (run && tick) begin
            // Reload of zero gives the full 256-count period
            if (cnt == 8'h01) begin
              cnt <= reload;
              wrapped <= 1'b1;
            end else begin
              cnt <= cnt - 8'h01;
            end
          end
          if (wrStb && sel == `ADCTSC_TMR_SEL_CTRL &&
              wrData[`ADCTSC_CW_SEL_HI:`ADCTSC_CW_SEL_LO] == IDX) begin
            run <= wrData[`ADCTSC_CW_RUN];
          end
        end
      end
      assign wrap[i] = wrapped;
      assign cntFlat[i*8 +: 8] = cnt;
    end
  endgenerate

  assign pacerTick = wrap[2];

  always @* begin
    rdData = 8'h00;
    if (sel != `ADCTSC_TMR_SEL_CTRL) begin
      rdData = cntFlat[sel*8 +: 8];
    end
  end

endmodule

// ==== hw/adctsc_trigger_scan.v ====
// Trigger source selection, channel scan and gain control of the acquisition card.
// Assumes a byte-wide I/O port on ref_clk with one-cycle read and write strobes.
// Function
// - Scan off: convert the programmed channel only
// - Scan on: mux value is last channel
// - Scan 0 to end channel, then wrap
// - Each rising trigger advances scan channel
// - Mux 8 bits: low nibble local, high external
// - High nibble addresses up to 16 boards
// - 12-bit variant reads back current channel
// - Sixteen single-ended local input channels
// - Five gain levels: 1,2,4,8,16
// - One gain shared by all channels
// - Conversion starts on selected trigger rising edge
// - External origin ignores both internal sources
// - Internal soft: any write triggers conversion
// - Internal pacer: cascaded counters trigger periodically
// - Trigger, transfer, interrupt settings independent
// - Timer window: counters 40h-44h, control 46h
// - Gain code 000..100 maps 1..16
// - Mode register fields at bits 3..0
`timescale 1ns/100ps
`include "adctsc_map.vh"

module adctsc_trigger_scan #(
  parameter HI_RES = 0, // 1 selects the high-resolution variant, no channel in the conversion data read
  parameter LOCAL_CHANS = 16 // Single-ended inputs on board
) (
  input wire ref_clk, // 40 MHz system clock
  input wire rst_n, // Asynchronous reset, active low
  input wire [7:0] ioAddr, // I/O offset from the card base
  input wire [7:0] ioWrData, // Write data
  input wire ioWrStb, // Write strobe, one cycle
  input wire ioRdStb, // Read strobe, one cycle
  output reg [7:0] ioRdData, // Read data, valid the cycle after the strobe
  input wire extTrigPin, // External trigger pin
  output reg convStart, // One-cycle conversion start pulse
  output wire [3:0] muxSel, // On-board input multiplexer select
  output wire [3:0] extSelOut, // Expansion board select
  output wire [2:0] gainCode, // Gain code to the amplifier
  output reg [4:0] gainFactor, // Decoded gain, one bit per level
  output wire pretriggerArm, // Stored pre-trigger control bit
  output wire autoScanActive, // Auto scan mode is on
  output wire pacerTick // Pacer pulse from the interval timer
);

  // ==========================================================================
  // Decoding helpers
  function hitOfs;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hitOfs = (addr == ofs);
    end
  endfunction

  function inTimer;
    input [7:0] addr;
    begin
      inTimer = ((addr & `ADCTSC_TMR_BASE_MASK) == `ADCTSC_TMR_BASE) && !addr[0];
    end
  endfunction

  function [4:0] gainOf;
    input [2:0] code;
    begin
      case (code)
        `ADCTSC_GCODE_X1: gainOf = `ADCTSC_GAIN_X1;
        `ADCTSC_GCODE_X2: gainOf = `ADCTSC_GAIN_X2;
        `ADCTSC_GCODE_X4: gainOf = `ADCTSC_GAIN_X4;
        `ADCTSC_GCODE_X8: gainOf = `ADCTSC_GAIN_X8;
        `ADCTSC_GCODE_X16: gainOf = `ADCTSC_GAIN_X16;
        // Undefined codes fall back to the widest range
        default: gainOf = `ADCTSC_GAIN_X1;
      endcase
    end
  endfunction

  // ==========================================================================
  // Write decode
  wire wrMux;
  wire wrGain;
  wire wrMode;
  wire wrSoft;
  wire wrTimer;

  assign wrMux = ioWrStb && hitOfs(ioAddr, `ADCTSC_OFS_CHAN_MUX);
  assign wrGain = ioWrStb && hitOfs(ioAddr, `ADCTSC_OFS_GAIN);
  assign wrMode = ioWrStb && hitOfs(ioAddr, `ADCTSC_OFS_TRIG_MODE);
  assign wrSoft = ioWrStb && hitOfs(ioAddr, `ADCTSC_OFS_SOFT_TRIG);
  assign wrTimer = ioWrStb && inTimer(ioAddr);

  // ==========================================================================
  // Control registers
  reg [7:0] chanMux;
  reg [2:0] gainReg;
  reg [3:0] modeReg;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chanMux <= `ADCTSC_RST_MUX;
      gainReg <= `ADCTSC_RST_GAIN;
      modeReg <= `ADCTSC_RST_MODE;
    end else begin
      if (wrMux) begin
        chanMux <= ioWrData;
      end
      if (wrGain) begin
        gainReg <= ioWrData[`ADCTSC_GAIN_W-1:0];
      end
      if (wrMode) begin
        modeReg <= ioWrData[`ADCTSC_MODE_W-1:0];
      end
    end
  end

  wire autoScan;
  wire pacerSel;
  wire extOrigin;

  assign autoScan = modeReg[`ADCTSC_BIT_AUTO_SCAN];
  assign pacerSel = modeReg[`ADCTSC_BIT_PACER_SOFT];
  assign extOrigin = modeReg[`ADCTSC_BIT_TRIG_ORIGIN];
  assign pretriggerArm = modeReg[`ADCTSC_BIT_PRETRIG];
  assign autoScanActive = autoScan;

  // ==========================================================================
  // Gain: one setting for every channel, untouched by scanning
  assign gainCode = gainReg;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gainFactor <= `ADCTSC_GAIN_X1;
    end else begin
      gainFactor <= gainOf(gainReg);
    end
  end

  // ==========================================================================
  // Interval timer
  wire [7:0] tmrRdData;

  adctsc_interval_timer #(
    .NUM_CNT(3)
  ) uTimer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wrStb(wrTimer),
    .sel(ioAddr[`ADCTSC_TMR_SEL_HI:`ADCTSC_TMR_SEL_LO]),
    .wrData(ioWrData),
    .rdData(tmrRdData),
    .pacerTick(pacerTick)
  );

  // ==========================================================================
  // External trigger: two-stage synchroniser, then edge detect
  reg extSync1;
  reg extSync2;
  reg extPrev;
  wire extRise;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extPrev <= 1'b0;
    end else begin
      extSync1 <= extTrigPin;
      extSync2 <= extSync1;
      extPrev <= extSync2;
    end
  end

  assign extRise = extSync2 && !extPrev;

  // ==========================================================================
  // Trigger source selection
  // Source choice is only the mode bits; transfer and interrupt never gate it
  reg trigHit;

  always @* begin
    trigHit = 1'b0;
    if (extOrigin) begin
      trigHit = extRise;
    end else if (pacerSel) begin
      trigHit = pacerTick;
    end else begin
      trigHit = wrSoft;
    end
  end

  // Mode writes own the cycle; a trigger landing on one is dropped, not held for later
  wire trigTake;
  assign trigTake = trigHit && !wrMode;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      convStart <= 1'b0;
    end else begin
      convStart <= trigTake;
    end
  end

  // ==========================================================================
  // Channel selection and auto scan
  reg [7:0] scanChan;
  reg [7:0] selChan;
  reg [7:0] next_scanChan;
  reg [7:0] next_selChan;
  wire scanTurnOn;

  assign scanTurnOn = wrMode && ioWrData[`ADCTSC_BIT_AUTO_SCAN] && !autoScan;

  always @* begin
    next_scanChan = scanChan;
    next_selChan = selChan;
    if (scanTurnOn) begin
      next_scanChan = 8'h00;
      next_selChan = 8'h00;
    end else if (!autoScan) begin
      next_selChan = chanMux;
      next_scanChan = 8'h00;
    end else if (trigTake) begin
      // Converted channel is latched; the counter moves to the next one
      next_selChan = scanChan;
      // Comparing >= also recovers if the end channel is lowered mid-scan
      if (scanChan >= chanMux) begin
        next_scanChan = 8'h00;
      end else begin
        next_scanChan = scanChan + 8'h01;
      end
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scanChan <= 8'h00;
      selChan <= 8'h00;
    end else begin
      scanChan <= next_scanChan;
      selChan <= next_selChan;
    end
  end

  // Low nibble reaches all on-board inputs, high nibble picks the board
  assign muxSel = selChan[3:0];
  assign extSelOut = selChan[7:4];

  // ==========================================================================
  // Read path
  reg [7:0] next_rdData;

  always @* begin
    next_rdData = 8'h00;
    if (inTimer(ioAddr)) begin
      next_rdData = tmrRdData;
    end else if (hitOfs(ioAddr, `ADCTSC_OFS_CONV_DATA)) begin
      // Only the 12-bit variant carries the channel beside its data
      next_rdData = (HI_RES == 0) ? {4'h0, selChan[3:0]} : 8'h00;
    end else if (hitOfs(ioAddr, `ADCTSC_OFS_CHAN_MUX)) begin
      next_rdData = selChan;
    end else if (hitOfs(ioAddr, `ADCTSC_OFS_GAIN)) begin
      next_rdData = {5'h00, gainReg};
    end else if (hitOfs(ioAddr, `ADCTSC_OFS_MODE_READBACK)) begin
      next_rdData = {4'h0, modeReg};
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ioRdData <= 8'h00;
    end else if (ioRdStb) begin
      ioRdData <= next_rdData;
    end
  end

endmodule

// ==== dv/adctsc_trigger_scan_monitor.sv ====
// Port-level checker of the trigger and scan control.
// Assumes single-cycle strobes on ref_clk and is bound to the top.
`timescale 1ns/100ps
module adctsc_trigger_scan_monitor (
  input wire ref_clk, // Clock
  input wire rst_n, // Reset
  input wire [7:0] ioAddr, // Offset
  input wire [7:0] ioWrData, // Write data
  input wire ioWrStb, // Write
  input wire ioRdStb, // Read
  input wire [7:0] ioRdData, // Read data
  input wire extTrigPin, // Ext trigger
  input wire convStart, // Start pulse
  input wire [3:0] muxSel, // Local select
  input wire [3:0] extSelOut, // Board select
  input wire [2:0] gainCode, // Gain code
  input wire [4:0] gainFactor, // Gain level
  input wire pretriggerArm, // Mode bit 3
  input wire autoScanActive, // Mode bit 0
  input wire pacerTick // Pacer pulse
);
  // ==========================================
  // Shadow of host writes
  reg [3:0] mode;
  reg [7:0] lastMux;
  reg [7:0] prevSel;
  reg seen;
  reg [3:0] quiet;
  wire wrM = ioWrStb && ioAddr == 8'h0a;
  wire [7:0] sel = {extSelOut, muxSel};
  function [4:0] gexp(input [2:0] c);
    gexp = (c > 3'h4) ? 5'h01 : 5'h01 << c;
  endfunction
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= 4'h0;
      lastMux <= 8'h00;
      prevSel <= 8'h00;
      seen <= 1'b0;
      quiet <= 4'h0;
    end else begin
      if (wrM)
        mode <= ioWrData[3:0];
      if (ioWrStb && ioAddr == 8'h06)
        lastMux <= ioWrData;
      if (convStart)
        prevSel <= sel;
      // Step check restarts whenever the scan is reprogrammed
      if (wrM || (ioWrStb && ioAddr == 8'h06))
        seen <= 1'b0;
      else if (convStart && autoScanActive)
        seen <= 1'b1;
      if (wrM || extTrigPin)
        quiet <= 4'h0;
      else if (quiet != 4'hf)
        quiet <= quiet + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Assertions
  a_soft_trig_start: assert property (ioWrStb && ioAddr == 8'h0e && mode[2:1] == 2'b00 |=> convStart)
    else $error("soft trigger gave no start");
  a_pacer_trig_start: assert property (pacerTick && mode[2:1] == 2'b01 && !wrM |=> convStart)
    else $error("pacer tick gave no start");
  a_ext_ignores_int: assert property (mode[2] && quiet > 4'h7 |-> !convStart)
    else $error("start without external edge");
  a_mux_follow: assert property (ioWrStb && ioAddr == 8'h06 && !autoScanActive |-> ##[1:2] sel == lastMux)
    else $error("select does not follow mux");
  a_single_hold: assert property (convStart && !autoScanActive && !$past(autoScanActive) && !$past(autoScanActive, 2)
    |-> sel == lastMux)
    else $error("single mode channel moved");
  a_scan_zero: assert property (wrM && ioWrData[0] && !autoScanActive |=> sel == 8'h00 && autoScanActive)
    else $error("scan did not start at zero");
  a_scan_range: assert property (convStart && autoScanActive |-> sel <= lastMux)
    else $error("scan beyond end channel");
  a_scan_step: assert property (convStart && autoScanActive && seen
    |-> sel == ((prevSel >= lastMux) ? 8'h00 : prevSel + 8'h01))
    else $error("scan step wrong");
  a_gain_decode: assert property (ioWrStb && ioAddr == 8'h08 |-> ##2 gainFactor == gexp($past(ioWrData[2:0], 2)))
    else $error("gain level wrong");
  a_mode_bits: assert property (wrM |=> autoScanActive == $past(ioWrData[0]) && pretriggerArm == $past(ioWrData[3]))
    else $error("mode bits wrong");
  a_mode_readback: assert property (ioRdStb && ioAddr == 8'h12 && !wrM |=> ioRdData == {4'h0, mode})
    else $error("mode readback wrong");
  a_ctrl_reads_zero: assert property (ioRdStb && ioAddr == 8'h46 |=> ioRdData == 8'h00)
    else $error("control word readable");
endmodule
bind adctsc_trigger_scan adctsc_trigger_scan_monitor mon_u (.ref_clk(ref_clk), .rst_n(rst_n), .ioAddr(ioAddr),
  .ioWrData(ioWrData), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb), .ioRdData(ioRdData), .extTrigPin(extTrigPin),
  .convStart(convStart), .muxSel(muxSel), .extSelOut(extSelOut), .gainCode(gainCode), .gainFactor(gainFactor),
  .pretriggerArm(pretriggerArm), .autoScanActive(autoScanActive), .pacerTick(pacerTick));

// ==== dv/adctsc_trigger_scan_bench.sv ====
// Self-checking bench of the trigger and scan control.
// Assumes the checker is bound in and the design sits on one 40 MHz clock.
`timescale 1ns/100ps
module adctsc_trigger_scan_bench;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] ioAddr = 8'h00;
  reg [7:0] ioWrData = 8'h00;
  reg ioWrStb = 1'b0;
  reg ioRdStb = 1'b0;
  reg extTrigPin = 1'b0;
  wire [7:0] ioRdData;
  wire convStart;
  wire [3:0] muxSel;
  wire [3:0] extSelOut;
  wire [2:0] gainCode;
  wire [4:0] gainFactor;
  wire pretriggerArm;
  wire autoScanActive;
  wire pacerTick;
  integer errCount = 0;
  integer nTests = 0;
  integer i;
  reg [7:0] d;
  reg [7:0] rows [0:5];
  always #12.5 ref_clk = ~ref_clk;
  adctsc_trigger_scan dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrData(ioWrData),
    .ioWrStb(ioWrStb), .ioRdStb(ioRdStb), .ioRdData(ioRdData), .extTrigPin(extTrigPin), .convStart(convStart),
    .muxSel(muxSel), .extSelOut(extSelOut), .gainCode(gainCode), .gainFactor(gainFactor),
    .pretriggerArm(pretriggerArm), .autoScanActive(autoScanActive), .pacerTick(pacerTick));
  // ==========================================
  // Tasks
  task reportAndStop;
    begin
      $display("checks %0d mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [7:0] s, input [7:0] e);
    begin
      nTests = nTests + 1;
      if (s !== e) begin
        errCount = errCount + 1;
        $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
    end
  endtask
  // Idle cycle before each strobe keeps one driver change per time step
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge ref_clk) #1;
      ioAddr = a;
      ioWrData = v;
      ioWrStb = 1'b1;
      @(posedge ref_clk) #1;
      ioWrStb = 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(posedge ref_clk) #1;
      ioAddr = a;
      ioRdStb = 1'b1;
      @(posedge ref_clk) #1;
      ioRdStb = 1'b0;
      v = ioRdData;
    end
  endtask
  task waitConv(input integer lim);
    integer j;
    begin
      for (j = 0; j < lim && convStart !== 1'b1; j = j + 1)
        @(posedge ref_clk) #1;
      nTests = nTests + 1;
      if (convStart !== 1'b1) begin
        errCount = errCount + 1;
        $display("mismatch at %0t: no conversion start", $time);
        reportAndStop;
      end
    end
  endtask
  // ==========================================
  // Sequence
  initial begin
    rows[0] = {3'h0, 5'h01};
    rows[1] = {3'h1, 5'h02};
    rows[2] = {3'h2, 5'h04};
    rows[3] = {3'h3, 5'h08};
    rows[4] = {3'h4, 5'h10};
    rows[5] = {3'h5, 5'h01};
    repeat (5) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk({3'h0, gainFactor}, 8'h01);
    chk({extSelOut, muxSel}, 8'h00);
    $display("test reset done");
    for (i = 0; i < 6; i = i + 1) begin
      wr(8'h08, {5'h00, rows[i][7:5]});
      @(posedge ref_clk) #1;
      chk({3'h0, gainFactor}, {3'h0, rows[i][4:0]});
      rd(8'h08, d);
      chk(d, {5'h00, rows[i][7:5]});
    end
    $display("test gain table done");
    wr(8'h06, 8'h35);
    @(posedge ref_clk) #1;
    chk({extSelOut, muxSel}, 8'h35);
    wr(8'h0e, 8'ha5);
    waitConv(8);
    chk({4'h0, muxSel}, 8'h05);
    rd(8'h00, d);
    chk(d, 8'h05);
    $display("test single channel done");
    wr(8'h06, 8'h02);
    wr(8'h0a, 8'h01);
    chk({extSelOut, muxSel}, 8'h00);
    rd(8'h12, d);
    chk(d, 8'h01);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h0e, 8'h00);
      waitConv(8);
      chk({extSelOut, muxSel}, (i == 3) ? 8'h00 : i[7:0]);
      chk({5'h00, gainCode}, 8'h05);
    end
    $display("test auto scan done");
    wr(8'h40, 8'h5a);
    rd(8'h40, d);
    chk(d, 8'h5a);
    rd(8'h46, d);
    chk(d, 8'h00);
    rd(8'h41, d);
    chk(d, 8'h00);
    wr(8'h0a, 8'h02);
    wr(8'h42, 8'h02);
    wr(8'h44, 8'h02);
    wr(8'h46, 8'h41);
    wr(8'h46, 8'h81);
    waitConv(60);
    $display("test pacer done");
    // Pacer keeps running here, so its ticks must be ignored too
    wr(8'h0a, 8'h0c);
    chk({6'h00, pretriggerArm, autoScanActive}, 8'h02);
    wr(8'h0e, 8'h33);
    repeat (8) begin
      @(posedge ref_clk) #1;
      chk({7'h00, convStart}, 8'h00);
    end
    extTrigPin = 1'b1;
    waitConv(8);
    extTrigPin = 1'b0;
    $display("test external trigger done");
    reportAndStop;
  end
endmodule
